// file: rtl/sarcc_pkg.sv
// Package for the successive-approximation conversion control block.
// Assumes a single 25 MHz clock and an analog front end driven by these controls.
package sarcc_pkg;
    localparam int RES_BITS = 14;
    localparam logic [13:0] CODE_ZERO = 14'h0000;
    localparam logic [13:0] CODE_FULL = 14'h3fff;
    localparam logic [13:0] CODE_MID = 14'h2000;
    localparam logic [3:0] MSB_INDEX = 4'hd;
    // Clock and conversion timing
    localparam int CLOCK_HZ = 25000000;
    localparam int MAX_RATE_SPS = 250000;
    localparam int CYCLES_PER_SAMPLE = CLOCK_HZ / MAX_RATE_SPS;
    // Conversion clock divider: one enable per CONV_DIV + 1 system clocks
    localparam logic [1:0] CONV_DIV = 2'h1;

    typedef enum logic [2:0] {
        SARCC_ACQUIRE = 3'h0,
        SARCC_OPEN_SW = 3'h1,
        SARCC_HOLD = 3'h2,
        SARCC_TRIAL = 3'h3,
        SARCC_DECIDE = 3'h4,
        SARCC_FINISH = 3'h5
    } sarcc_state_t;

    // Analog switch controls as one group
    typedef struct packed {
        logic positive_sample_switch;
        logic negative_sample_switch;
        logic inputs_connected;
        logic powered;
    } sarcc_analog_t;
endpackage : sarcc_pkg

// file: rtl/sarcc_control.sv
// Successive-approximation conversion control, 14 bits, MSB first.
// Assumes the comparator and range flags are synchronous to clock.
// Summary of operation
// - Rising convert_start ends acquisition and begins a conversion.
// - Open both sample switches first, then ground the arrays.
// - Fourteen binary-weighted trial steps, most significant bit first.
// - After search, return to acquisition, present code and busy.
// - Sequence paced by internal conversion clock, no serial clock used.
// - Result belongs to the sample taken at that same start.
// - Supports 250 kSPS and powers down between conversions.
// - Output is 14-bit straight binary, midscale 0x2000.
// - Over-range input saturates at all ones.
// - Under-range input clamps at all zeros.
// - A started conversion completes whatever convert_start does.
`timescale 1ns/10ps
`default_nettype none
module sarcc_control (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host start
    input wire logic convert_start,
    // Comparator: high when trial does not exceed held input
    input wire logic comparator_keep,
    input wire logic over_range,
    input wire logic under_range,
    // Analog controls
    output sarcc_pkg::sarcc_analog_t analog,
    output logic [13:0] dac_code,
    // Result
    output logic [13:0] result,
    output logic result_ready,
    output logic busy
);
    sarcc_pkg::sarcc_state_t state, next_state;
    logic start_prev;
    logic [1:0] div_count;
    logic [3:0] bit_index;
    logic [13:0] trial;
    logic over_seen, under_seen;

    // One-hot weight of a trial bit
    function automatic logic [13:0] onehot(input logic [3:0] idx);
        onehot = 14'h0001 << idx;
    endfunction : onehot

    wire start_edge = convert_start & ~start_prev;
    wire conv_tick = (div_count == sarcc_pkg::CONV_DIV);
    // Search ends after the least significant trial
    wire last_bit = (bit_index == 4'h0);
    wire [13:0] kept = comparator_keep ? trial : (trial & ~onehot(bit_index));
    // saturation, straight binary otherwise
    // Over-range wins over under-range
    wire [13:0] final_code = over_seen ? sarcc_pkg::CODE_FULL :
                             under_seen ? sarcc_pkg::CODE_ZERO : kept;

    always_comb begin
        next_state = state;
        unique case (state)
            sarcc_pkg::SARCC_ACQUIRE: if (start_edge) next_state = sarcc_pkg::SARCC_OPEN_SW;
            sarcc_pkg::SARCC_OPEN_SW: if (conv_tick) next_state = sarcc_pkg::SARCC_HOLD;
            sarcc_pkg::SARCC_HOLD: if (conv_tick) next_state = sarcc_pkg::SARCC_TRIAL;
            sarcc_pkg::SARCC_TRIAL: if (conv_tick) next_state = sarcc_pkg::SARCC_DECIDE;
            sarcc_pkg::SARCC_DECIDE: begin
                if (conv_tick) begin
                    next_state = last_bit ? sarcc_pkg::SARCC_FINISH : sarcc_pkg::SARCC_TRIAL;
                end
            end
            sarcc_pkg::SARCC_FINISH: next_state = sarcc_pkg::SARCC_ACQUIRE;
            default: next_state = sarcc_pkg::SARCC_ACQUIRE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= sarcc_pkg::SARCC_ACQUIRE;
            start_prev <= 1'b0;
            div_count <= 2'h0;
        end else begin
            state <= next_state;
            start_prev <= convert_start;
            // Divider restarts on each tick so the pace follows CONV_DIV
            div_count <= (state == sarcc_pkg::SARCC_ACQUIRE || conv_tick) ? 2'h0 :
                         div_count + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_index <= sarcc_pkg::MSB_INDEX;
            trial <= sarcc_pkg::CODE_ZERO;
            over_seen <= 1'b0;
            under_seen <= 1'b0;
        end else if (state == sarcc_pkg::SARCC_HOLD && conv_tick) begin
            bit_index <= sarcc_pkg::MSB_INDEX;
            trial <= sarcc_pkg::CODE_MID;
            over_seen <= over_range;
            under_seen <= under_range;
        end else if (state == sarcc_pkg::SARCC_DECIDE && conv_tick) begin
            // keep bit on no overshoot, then try next
            trial <= last_bit ? kept : (kept | onehot(bit_index - 4'h1));
            if (!last_bit) bit_index <= bit_index - 4'h1;
        end
    end

    // result of this conversion, no pipeline
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            result <= sarcc_pkg::CODE_ZERO;
            result_ready <= 1'b0;
        end else if (state == sarcc_pkg::SARCC_DECIDE && conv_tick && last_bit) begin
            result <= final_code;
            result_ready <= 1'b1;
        end else if (start_edge && state == sarcc_pkg::SARCC_ACQUIRE) begin
            result_ready <= 1'b0;
        end
    end

    wire acquiring = (state == sarcc_pkg::SARCC_ACQUIRE);
    // power only while converting; busy held to completion
    assign busy = ~acquiring;
    // Switches closed only while acquiring; arrays on the inputs while acquiring and in SARCC_OPEN_SW
    assign analog.positive_sample_switch = acquiring;
    assign analog.negative_sample_switch = acquiring;
    assign analog.inputs_connected = acquiring | (state == sarcc_pkg::SARCC_OPEN_SW);
    assign analog.powered = ~acquiring;
    assign dac_code = trial;

    chk_switch_order: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> !analog.positive_sample_switch && analog.inputs_connected)
        else $error("switches not opened before disconnect");
    chk_start_begins: assert property (@(posedge clock) disable iff (!reset_n)
        (acquiring && start_edge) |=> busy)
        else $error("start did not begin conversion");
    chk_run_complete: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> busy [*8])
        else $error("conversion cut short");
    chk_conv_length: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> ##[60:62] !busy)
        else $error("conversion length wrong");
    chk_ready_end: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(result_ready) |=> !busy)
        else $error("did not return to acquisition");
    chk_over_sat: assert property (@(posedge clock) disable iff (!reset_n)
        ($rose(result_ready) && over_seen) |-> result == sarcc_pkg::CODE_FULL)
        else $error("over-range not saturated");
    chk_under_clamp: assert property (@(posedge clock) disable iff (!reset_n)
        ($rose(result_ready) && under_seen && !over_seen) |-> result == sarcc_pkg::CODE_ZERO)
        else $error("under-range not clamped");
    chk_power_down: assert property (@(posedge clock) disable iff (!reset_n)
        !busy |-> !analog.powered && analog.positive_sample_switch)
        else $error("not powered down in acquisition");
    chk_trial_msb: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_TRIAL && bit_index == sarcc_pkg::MSB_INDEX)
        |-> dac_code == sarcc_pkg::CODE_MID)
        else $error("first trial not midscale");

    // Sequencing checks
    chk_neg_switch: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> !analog.negative_sample_switch && analog.inputs_connected)
        else $error("negative switch not opened first");
    chk_arrays_grounded: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_HOLD) |-> !analog.inputs_connected)
        else $error("arrays still on inputs in hold");
    chk_start_refused: assert property (@(posedge clock) disable iff (!reset_n)
        (busy && state != sarcc_pkg::SARCC_FINISH && start_edge) |=> busy)
        else $error("start during conversion disturbed it");
    chk_tick_pace: assert property (@(posedge clock) disable iff (!reset_n)
        conv_tick |=> !conv_tick)
        else $error("conversion tick too fast");

    // Search checks
    chk_bit_step: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_DECIDE && conv_tick && !last_bit)
        |=> bit_index == $past(bit_index) - 4'h1)
        else $error("trial bit did not step down");
    chk_trial_set: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_TRIAL) |-> dac_code[bit_index])
        else $error("trial bit not set");
    chk_low_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_TRIAL) |-> (dac_code & (onehot(bit_index) - 14'h1)) == 14'h0)
        else $error("bits below trial not clear");
    chk_drop_over: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_DECIDE && conv_tick && !comparator_keep && !last_bit)
        |=> !dac_code[$past(bit_index)])
        else $error("overshooting bit kept");
    chk_keep_bit: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_DECIDE && conv_tick && comparator_keep && !last_bit)
        |=> dac_code[$past(bit_index)])
        else $error("good bit dropped");

    // Result checks
    chk_ready_clear: assert property (@(posedge clock) disable iff (!reset_n)
        (acquiring && start_edge) |=> !result_ready)
        else $error("ready not cleared by start");
    chk_result_hold: assert property (@(posedge clock) disable iff (!reset_n)
        (acquiring && $past(acquiring)) |-> $stable(result))
        else $error("result changed while acquiring");
    chk_busy_ready: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(busy) |-> result_ready)
        else $error("busy fell without result");
    chk_range_capture: assert property (@(posedge clock) disable iff (!reset_n)
        (state == sarcc_pkg::SARCC_HOLD && conv_tick) |=> over_seen == $past(over_range))
        else $error("over-range not captured at hold");

    // Power and rate checks
    chk_powered_busy: assert property (@(posedge clock) disable iff (!reset_n)
        busy |-> analog.powered)
        else $error("not powered while converting");
    chk_rate_fit: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(busy) |-> ##[1:95] !busy)
        else $error("conversion too long for full rate");

    // Scenario coverage
    cov_conversion: cover property (@(posedge clock) disable iff (!reset_n) $rose(result_ready));
    cov_over: cover property (@(posedge clock) disable iff (!reset_n) $rose(result_ready) && over_seen);
    cov_restart: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy) ##[1:20] busy);
    cov_under: cover property (@(posedge clock) disable iff (!reset_n) $rose(result_ready) && under_seen);
    cov_refused: cover property (@(posedge clock) disable iff (!reset_n) busy && start_edge);
endmodule : sarcc_control
`default_nettype wire

// file: dv/sarcc_front_model.sv
// Front end model: sample-hold and comparator.
// Assumes the block grounds the arrays to freeze the sample.
`timescale 1ns/10ps
`default_nettype none
module sarcc_front_model (
    // From the block
    input wire sarcc_pkg::sarcc_analog_t analog,
    input wire logic [13:0] dac_code,
    // Live input, comparator out
    input wire logic [13:0] live_input,
    output logic comparator_keep
);
    logic [13:0] held;
    always_latch begin
        if (analog.inputs_connected) begin
            held <= live_input;
        end
    end
    assign comparator_keep = (dac_code <= held);
endmodule : sarcc_front_model
`default_nettype wire

// file: dv/sarcc_control_tb.sv
// Bench for the conversion control block.
// Assumes the front end model answers the comparator.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch %0t %s", $time, m); end end
module sarcc_control_tb;
    logic clock, reset_n, convert_start, over_range, under_range, keep, result_ready, busy;
    logic [13:0] dac_code, result, live_input;
    sarcc_pkg::sarcc_analog_t analog;
    int error_cnt = 0;
    int checks = 0;
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    sarcc_control dut (.clock(clock), .reset_n(reset_n), .convert_start(convert_start),
        .comparator_keep(keep), .over_range(over_range), .under_range(under_range),
        .analog(analog), .dac_code(dac_code), .result(result),
        .result_ready(result_ready), .busy(busy));
    sarcc_front_model model (.analog(analog), .dac_code(dac_code),
        .live_input(live_input), .comparator_keep(keep));
    task summarize;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // One conversion, input changed and start toggled mid-way
    task convert(input logic [13:0] vin, input logic ov, input logic un,
                 input logic [13:0] expect_code);
        int k;
        @(negedge clock);
        live_input = vin; over_range = ov; under_range = un; convert_start = 1'b0;
        @(negedge clock);
        convert_start = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(busy, 1'b1, "busy")
        `CHK({analog.positive_sample_switch, analog.negative_sample_switch}, 2'h0, "sw")
        `CHK(analog.inputs_connected, 1'b1, "still on inputs")
        repeat (5) @(negedge clock);
        `CHK(analog.inputs_connected, 1'b0, "grounded")
        live_input = ~vin; convert_start = 1'b0;
        repeat (20) @(negedge clock);
        convert_start = 1'b1;
        k = 27;
        while (busy === 1'b1 && k < 300) begin @(negedge clock); k++; end
        `CHK(k >= 61 && k <= 63, 1'b1, "conversion length")
        `CHK({result_ready, analog.powered}, 2'h2, "ready, powered down")
        `CHK(result, expect_code, "code")
        repeat (3) @(negedge clock);
        `CHK(busy, 1'b0, "late start ignored")
    endtask : convert
    task t_codes;
        convert(14'h2000, 1'b0, 1'b0, 14'h2000);
        convert(14'h2001, 1'b0, 1'b0, 14'h2001);
        convert(14'h1fff, 1'b0, 1'b0, 14'h1fff);
        convert(14'h0000, 1'b0, 1'b0, 14'h0000);
        $display("test codes done");
    endtask : t_codes
    task t_range;
        convert(14'h0100, 1'b1, 1'b0, 14'h3fff);
        convert(14'h3f00, 1'b0, 1'b1, 14'h0000);
        $display("test range done");
    endtask : t_range
    initial begin
        reset_n = 1'b0; convert_start = 1'b0; over_range = 1'b0; under_range = 1'b0;
        live_input = 14'h0000;
        repeat (3) @(negedge clock);
        `CHK({busy, result_ready, result, analog.powered}, 17'h0, "reset values")
        reset_n = 1'b1;
        t_codes;
        t_range;
        summarize;
    end
    initial begin
        #200000;
        error_cnt++;
        summarize;
    end
endmodule : sarcc_control_tb
`default_nettype wire
